// >>> logic/iviop_bus_if.sv
/*
  The processor I/O bus between the bus controller and the port.
  Assumes one clock; the read return is resolved here from the port's enable.
*/
`timescale 1ns/100ps
interface iviop_bus_if;
  import iviop_pkg::*;
  `include "iviop_consts.svh"

  logic addr_cycle;
  logic wr_left;
  logic wr_right;
  logic rd_left;
  logic rd_right;
  iviop_byte_t wr_data;
  iviop_byte_t rd_data;
  logic rd_oe;
  iviop_byte_t rd_value;

  // Undriven bus floats high as with pull-ups
  assign rd_value = rd_oe ? rd_data : `IVIOP_IDLE_BUS;

  modport port_end (
    input addr_cycle, wr_left, wr_right, rd_left, rd_right, wr_data,
    output rd_data, rd_oe
  );

  modport ctrl_end (
    output addr_cycle, wr_left, wr_right, rd_left, rd_right, wr_data,
    input rd_value
  );
endinterface

// >>> logic/iviop_consts.svh
/*
  Constants shared by both ends of the interface vector I/O port link:
  register offsets and fields of the host command block, reset values.
  Assumes it is included by bare name after the package is compiled.
*/
// Operation
// RULE1 - Port answers only its own fixed address
// RULE2 - Select address before each byte access
// RULE3 - Left and right banks select independently
// RULE4 - Read left, write right in one cycle
// RULE5 - Selection holds until same bank rewritten
// RULE6 - Select registers are write only
// RULE7 - User reads output latch at any time
// RULE8 - Select addresses span zero through 255
// RULE9 - Eight latches, eight lines, two controls
// RULE10 - Both controls high: lines float
// RULE11 - Output control low: drive latch (code drives only while input control is high)
// RULE12 - Input control low: lines are inputs
// RULE13 - Bus flags address cycles versus data
// RULE14 - Selected port loads writes, answers reads
`ifndef IVIOP_CONSTS_SVH
`define IVIOP_CONSTS_SVH

// Host register offsets (byte addresses, one aligned word each)
`define IVIOP_CMD_OFS 8'h00
`define IVIOP_RESULT_OFS 8'h04

// Command register fields
`define IVIOP_CMD_DATA_LSB 0
`define IVIOP_CMD_DATA_MSB 7
`define IVIOP_CMD_OP_LSB 8
`define IVIOP_CMD_OP_MSB 10

// Result register fields
`define IVIOP_RES_DATA_LSB 0
`define IVIOP_RES_DATA_MSB 7
`define IVIOP_RES_DRIVEN_BIT 8
`define IVIOP_RES_COUNT_LSB 16
`define IVIOP_RES_COUNT_MSB 23

// Reset values
`define IVIOP_LATCH_RST 8'h00
`define IVIOP_SELECT_RST 8'h00
`define IVIOP_IDLE_BUS 8'hff

// AXI responses
`define IVIOP_RESP_OKAY 2'b00
`define IVIOP_RESP_SLVERR 2'b10

`endif

// >>> logic/iviop_ctrl.sv
/*
  Bus controller: an AXI4-Lite slave whose command register drives one
  processor bus cycle per write and whose result register holds the read byte.
  Assumes a single port end on the bus and one clock.
*/
`timescale 1ns/100ps
module iviop_ctrl
  import iviop_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor bus
  iviop_bus_if.ctrl_end bus
);
  `include "iviop_consts.svh"

  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic cmd_hit;
  iviop_op_e op_reg;
  iviop_byte_t data_reg;
  iviop_byte_t result_reg;
  logic driven_reg;
  logic [7:0] count_reg;
  logic is_read;

  // Command offset decode, shared by the write and the read paths
  function automatic logic is_cmd_ofs(input logic [7:0] a);
    is_cmd_ofs = (a == `IVIOP_CMD_OFS);
  endfunction

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign cmd_hit = is_cmd_ofs(awaddr_reg) && wstrb_reg[1];

  // Address and data are captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IVIOP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_cmd_ofs(awaddr_reg) ? `IVIOP_RESP_OKAY : `IVIOP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // A command launches exactly one bus cycle; the byte lane alone keeps
  // the previous value, so lane 1 is the trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_reg <= IVIOP_OP_NONE;
    end else if (do_write && cmd_hit) begin
      op_reg <= iviop_op_e'(wdata_reg[`IVIOP_CMD_OP_MSB:`IVIOP_CMD_OP_LSB]);  // RULE2
    end else begin
      op_reg <= IVIOP_OP_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= 8'h00;
    end else if (do_write && is_cmd_ofs(awaddr_reg) && wstrb_reg[0]) begin
      data_reg <= wdata_reg[`IVIOP_CMD_DATA_MSB:`IVIOP_CMD_DATA_LSB];
    end
  end

  // Bus strobes; selects are written only, never read back
  assign bus.addr_cycle = (op_reg == IVIOP_OP_SEL_LEFT) || (op_reg == IVIOP_OP_SEL_RIGHT);  // RULE13 RULE6
  assign bus.wr_left = (op_reg == IVIOP_OP_SEL_LEFT) || (op_reg == IVIOP_OP_WR_LEFT);  // RULE3
  assign bus.wr_right = (op_reg == IVIOP_OP_SEL_RIGHT) || (op_reg == IVIOP_OP_WR_RIGHT) ||
                        (op_reg == IVIOP_OP_MOVE);  // RULE3 RULE4
  assign bus.rd_left = (op_reg == IVIOP_OP_RD_LEFT) || (op_reg == IVIOP_OP_MOVE);  // RULE4
  assign bus.rd_right = (op_reg == IVIOP_OP_RD_RIGHT);
  // Move forwards the left read straight to the right write
  assign bus.wr_data = (op_reg == IVIOP_OP_MOVE) ? bus.rd_value : data_reg;  // RULE4

  assign is_read = (op_reg == IVIOP_OP_RD_LEFT) || (op_reg == IVIOP_OP_RD_RIGHT) ||
                   (op_reg == IVIOP_OP_MOVE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= 8'h00;
      driven_reg <= 1'b0;
      count_reg <= 8'h00;
    end else if (is_read) begin
      result_reg <= bus.rd_value;
      driven_reg <= (bus.rd_value != `IVIOP_IDLE_BUS) || (count_reg == 8'hff);
      count_reg <= count_reg + 8'h01;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IVIOP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (is_cmd_ofs(s_axi_araddr)) begin
        s_axi_rdata <= {21'h000000, op_reg, data_reg};
        s_axi_rresp <= `IVIOP_RESP_OKAY;
      end else if (s_axi_araddr == `IVIOP_RESULT_OFS) begin
        s_axi_rdata <= {8'h00, count_reg, 7'h00, driven_reg, result_reg};
        s_axi_rresp <= `IVIOP_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `IVIOP_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // iviop_ctrl

// >>> logic/iviop_pkg.sv
/*
  Types for the interface vector I/O port link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iviop_pkg;

  typedef logic [7:0] iviop_byte_t;

  typedef enum logic [2:0] {
    IVIOP_OP_SEL_LEFT = 3'b000,
    IVIOP_OP_SEL_RIGHT = 3'b001,
    IVIOP_OP_WR_LEFT = 3'b010,
    IVIOP_OP_WR_RIGHT = 3'b011,
    IVIOP_OP_RD_LEFT = 3'b100,
    IVIOP_OP_RD_RIGHT = 3'b101,
    IVIOP_OP_MOVE = 3'b110,
    IVIOP_OP_NONE = 3'b111
  } iviop_op_e;

endpackage

// >>> logic/iviop_port.sv
/*
  One interface vector byte: an addressable 8-bit bidirectional I/O port.
  Holds its own left and right bank selection by watching address cycles.
  Assumes the controller flags address cycles and never reads the selects.
*/
`timescale 1ns/100ps
module iviop_port
  import iviop_pkg::*;
#(
  // Field-programmed address of this byte
  parameter logic [7:0] PORT_ADDR = 8'h00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Processor bus
  iviop_bus_if.port_end bus,
  // User lines, split into input, output and enable
  input wire logic [7:0] user_data_in,
  output logic [7:0] user_data_out,
  output logic [7:0] user_data_oe,
  // User controls, active low
  input wire logic byte_input_control_n,
  input wire logic byte_output_control_n,
  // User-side view of the latch and of the selection
  output logic [7:0] port_vector,
  output logic left_selected,
  output logic right_selected,
  output logic user_load_pulse
);
  `include "iviop_consts.svh"

  logic [7:0] left_bank_select_reg;
  logic [7:0] right_bank_select_reg;
  logic left_valid_reg;
  logic right_valid_reg;
  logic [7:0] latch_reg;
  logic load_reg;
  logic left_hit;
  logic right_hit;
  logic data_cycle;
  logic wr_hit;
  logic rd_hit;
  logic input_mode;
  logic output_mode;

  // Full 8-bit compare so every address 0..255 can be told apart
  function automatic logic addr_match(input logic valid, input logic [7:0] sel);
    addr_match = valid && (sel == PORT_ADDR);  // RULE1 RULE8
  endfunction

  // Left bank selection: only left address cycles touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_bank_select_reg <= `IVIOP_SELECT_RST;
      left_valid_reg <= 1'b0;
    end else if (bus.addr_cycle && bus.wr_left) begin  // RULE13
      left_bank_select_reg <= bus.wr_data;  // RULE3 RULE5
      left_valid_reg <= 1'b1;
    end
  end

  // Right bank selection, independent of the left one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      right_bank_select_reg <= `IVIOP_SELECT_RST;
      right_valid_reg <= 1'b0;
    end else if (bus.addr_cycle && bus.wr_right) begin  // RULE13
      right_bank_select_reg <= bus.wr_data;  // RULE3 RULE5
      right_valid_reg <= 1'b1;
    end
  end

  // Nothing is selected after reset, so a stray data cycle hits no port
  assign left_hit = addr_match(left_valid_reg, left_bank_select_reg);
  assign right_hit = addr_match(right_valid_reg, right_bank_select_reg);
  assign left_selected = left_hit;
  assign right_selected = right_hit;

  // Only data cycles move bytes; address cycles are never compared as data
  assign data_cycle = !bus.addr_cycle;  // RULE13
  assign wr_hit = data_cycle && ((bus.wr_left && left_hit) || (bus.wr_right && right_hit));
  assign rd_hit = data_cycle && ((bus.rd_left && left_hit) || (bus.rd_right && right_hit));

  // Storage latches; the latch loads even in input mode so a later
  // switch to output mode shows the last byte the processor wrote
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= `IVIOP_LATCH_RST;
    end else if (wr_hit) begin
      latch_reg <= bus.wr_data;  // RULE14 RULE9
    end
  end

  // One-cycle notice to the user side that a new byte arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= wr_hit;
    end
  end
  assign user_load_pulse = load_reg;

  // Input control wins over output control
  assign input_mode = !byte_input_control_n;  // RULE12
  assign output_mode = byte_input_control_n && !byte_output_control_n;  // RULE11

  // Both controls high leaves the lines undriven
  assign user_data_oe = output_mode ? 8'hff : 8'h00;  // RULE10 RULE11
  assign user_data_out = latch_reg;  // RULE11

  // Latch is visible whether or not the processor has this port selected
  assign port_vector = latch_reg;  // RULE7

  // Read answer is combinational so a left read can feed a right write
  // in the same cycle; the cost is a longer path through the user lines
  assign bus.rd_oe = rd_hit;  // RULE14 RULE4
  assign bus.rd_data = input_mode ? user_data_in : latch_reg;  // RULE12 RULE14

endmodule // iviop_port

// >>> testbench/iviop_bus_sva.sv
/*
  Concurrent checks on the processor bus between the controller and the port.
  Assumes one clock and the bus signals wired in as plain inputs.
*/
`timescale 1ns/100ps
module iviop_bus_sva
  import iviop_pkg::*;
#(
  parameter logic [7:0] PORT_ADDR = 8'h00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire logic addr_cycle,
  input wire logic wr_left,
  input wire logic wr_right,
  input wire logic rd_left,
  input wire logic rd_right,
  input wire iviop_byte_t wr_data,
  // Port side
  input wire iviop_byte_t rd_data,
  input wire logic rd_oe,
  input wire iviop_byte_t rd_value
);
  `include "iviop_consts.svh"

  logic left_sel_reg;
  logic right_sel_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Shadow selections; cleared by reset so port zero is not picked by default
  always_ff @(posedge aclk) begin
    if (!aresetn)
      left_sel_reg <= 1'b0;
    else if (addr_cycle && wr_left)
      left_sel_reg <= (wr_data == PORT_ADDR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      right_sel_reg <= 1'b0;
    else if (addr_cycle && wr_right)
      right_sel_reg <= (wr_data == PORT_ADDR);
  end

  a_left_select: assert property (rd_left && !addr_cycle |-> rd_oe == left_sel_reg)
    else $error("left read answer disagrees with selection");
  a_right_select: assert property (rd_right && !addr_cycle |-> rd_oe == right_sel_reg)
    else $error("right read answer disagrees with selection");
  a_oe_on_read: assert property (rd_oe |-> (rd_left || rd_right))
    else $error("port drives bus outside a read");
  a_move_byte: assert property (rd_left && wr_right |-> wr_data == rd_value)
    else $error("move does not carry the left byte");
  a_addr_one_bank: assert property (addr_cycle |-> (wr_left ^ wr_right))
    else $error("address cycle without exactly one bank write");
  a_addr_no_read: assert property (addr_cycle |-> !(rd_left || rd_right))
    else $error("select register read attempted");
  a_strobe_single: assert property ((wr_left || wr_right || rd_left || rd_right)
    |=> !(wr_left || wr_right || rd_left || rd_right))
    else $error("bus strobe longer than one cycle");
  a_read_one_bank: assert property (!(rd_left && rd_right))
    else $error("both banks read at once");
  a_read_return: assert property (rd_oe |-> rd_value == rd_data)
    else $error("bus does not carry the port read byte");
  a_idle_high: assert property (!rd_oe |-> rd_value == `IVIOP_IDLE_BUS)
    else $error("undriven bus does not read high");
  a_oe_data_only: assert property (rd_oe |-> !addr_cycle)
    else $error("port drives bus in an address cycle");
endmodule // iviop_bus_sva

// >>> testbench/test_interface_vector_io_port.sv
/*
  Self-checking bench: AXI4-Lite master, controller and port joined by the bus.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/100ps
module test_interface_vector_io_port;
  import iviop_pkg::*;
  `include "iviop_consts.svh"
  localparam logic [7:0] PORT_ADDR = 8'hff;
  localparam logic [7:0] OTHER = 8'h00;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'h3;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] tb_user = 8'hc3;
  logic [7:0] user_data_in, user_data_out, user_data_oe, port_vector;
  logic byte_input_control_n = 1'b1;
  logic byte_output_control_n = 1'b1;
  logic left_selected, right_selected, user_load_pulse;
  int failures = 0;
  int n_checks = 0;

  always #12.5 aclk = ~aclk;
  // Resolved user lines: port wins where it drives
  assign user_data_in = (user_data_oe & user_data_out) | (~user_data_oe & tb_user);

  iviop_bus_if u_iviop_bus_if ();
  iviop_ctrl u_iviop_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus(u_iviop_bus_if));
  iviop_port #(.PORT_ADDR(PORT_ADDR)) u_iviop_port (.aclk(aclk), .aresetn(aresetn),
    .bus(u_iviop_bus_if), .user_data_in(user_data_in), .user_data_out(user_data_out),
    .user_data_oe(user_data_oe), .byte_input_control_n(byte_input_control_n),
    .byte_output_control_n(byte_output_control_n), .port_vector(port_vector),
    .left_selected(left_selected), .right_selected(right_selected),
    .user_load_pulse(user_load_pulse));
  iviop_bus_sva #(.PORT_ADDR(PORT_ADDR)) u_iviop_bus_sva (.aclk(aclk), .aresetn(aresetn),
    .addr_cycle(u_iviop_bus_if.addr_cycle), .wr_left(u_iviop_bus_if.wr_left),
    .wr_right(u_iviop_bus_if.wr_right), .rd_left(u_iviop_bus_if.rd_left),
    .rd_right(u_iviop_bus_if.rd_right), .wr_data(u_iviop_bus_if.wr_data),
    .rd_data(u_iviop_bus_if.rd_data), .rd_oe(u_iviop_bus_if.rd_oe),
    .rd_value(u_iviop_bus_if.rd_value));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready is sampled right after the edge, before that edge's updates land
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!(awready && wready) && !(awready && !wvalid) && !(wready && !awvalid));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic cmd(input iviop_op_e op, input logic [7:0] d);
    logic [1:0] r;
    axi_write(`IVIOP_CMD_OFS, {21'h0, op, d}, r);
  endtask

  task automatic read_left(output logic [7:0] b);
    logic [31:0] d;
    logic [1:0] r;
    cmd(IVIOP_OP_RD_LEFT, 8'h00);
    axi_read(`IVIOP_RESULT_OFS, d, r);
    b = d[7:0];
  endtask

  task automatic t_unselected;
    logic [1:0] r;
    logic [7:0] b;
    logic [31:0] d;
    axi_write(8'h0c, 32'h0000_0200, r);
    check(r, `IVIOP_RESP_SLVERR);
    axi_read(8'h0c, d, r);
    check(d, 32'h0000_0000);
    check(r, `IVIOP_RESP_SLVERR);
    read_left(b);
    check(b, `IVIOP_IDLE_BUS);
    cmd(IVIOP_OP_SEL_LEFT, OTHER);
    cmd(IVIOP_OP_WR_LEFT, 8'h5a);
    @(posedge aclk);
    check(port_vector, `IVIOP_LATCH_RST);
    check(user_load_pulse, 1'b0);
    axi_read(`IVIOP_CMD_OFS, d, r);
    check(d, 32'h0000_075a);
  endtask

  task automatic t_select_hold;
    logic [7:0] b;
    cmd(IVIOP_OP_SEL_LEFT, PORT_ADDR);
    cmd(IVIOP_OP_SEL_RIGHT, OTHER);
    cmd(IVIOP_OP_WR_RIGHT, 8'h77);
    cmd(IVIOP_OP_WR_LEFT, 8'h3c);
    @(posedge aclk);
    check({left_selected, right_selected}, 2'b10);
    check(user_load_pulse, 1'b1);
    check(port_vector, 8'h3c);
    read_left(b);
    check(b, 8'h3c);
  endtask

  task automatic t_move_and_modes;
    logic [7:0] b;
    logic [1:0] m;
    logic [31:0] d;
    logic [1:0] r;
    cmd(IVIOP_OP_SEL_RIGHT, PORT_ADDR);
    byte_input_control_n <= 1'b0;
    cmd(IVIOP_OP_MOVE, 8'h00);
    @(posedge aclk);
    check({right_selected, port_vector}, {1'b1, tb_user});
    // User lines now differ from the latch so the read source shows
    tb_user <= 8'h96;
    cmd(IVIOP_OP_RD_RIGHT, 8'h00);
    axi_read(`IVIOP_RESULT_OFS, d, r);
    check(d, 32'h0004_0196);
    check(r, `IVIOP_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      {byte_input_control_n, byte_output_control_n} <= m;
      read_left(b);
      check(user_data_oe, (m == 2'b10) ? 8'hff : 8'h00);
      check(b, m[1] ? 8'hc3 : 8'h96);
    end
    tb_user <= 8'h18;
    byte_input_control_n <= 1'b1;
    byte_output_control_n <= 1'b0;
    cmd(IVIOP_OP_SEL_LEFT, OTHER);
    cmd(IVIOP_OP_SEL_RIGHT, OTHER);
    read_left(b);
    check(b, `IVIOP_IDLE_BUS);
    check(user_data_out, 8'hc3);
    check(user_data_in, 8'hc3);
  endtask

  task automatic t_reset_clears;
    logic [7:0] b;
    cmd(IVIOP_OP_SEL_LEFT, PORT_ADDR);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    check({left_selected, right_selected, port_vector}, 10'h000);
    aresetn <= 1'b1;
    read_left(b);
    check(b, `IVIOP_IDLE_BUS);
  endtask

  task automatic give_verdict;
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_unselected();
    t_select_hold();
    t_move_and_modes();
    t_reset_clears();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    give_verdict();
  end
endmodule // test_interface_vector_io_port
